// *** design/bcc_regs.svh ***
// register map, field positions and constants of the bus and cache control block
// Overview of operation
// - cache-allow high: no cache use that cycle
// - cacheable only if (nocache|writethru)=0, allow=0
// - paging on: page nocache bit gates caching
// - paging on: writethru bit stops data caching
// - page-attribute pin shows selected page bit on reads; held low on write cycles
// - paging off: page-attribute pin held low
// - invalidate bit flushes icache and TLB
// - one flush request flushes one block
// - up to three outstanding bus cycles
// - hits deliver 64b fetch, 128b load per cycle
// - same-row hint when row matches previous
// - three-bit field selects DRAM row size
// - byte-boot: 8-bit fetches, else 64-bit
// - byte-boot set only by reset-time strap
// - byte-boot fetch on low byte lane
// - byte-boot: low lane selects carry address
// - cleared byte-boot stays clear until reset
// - two 128-bit write buffers, drained when idle
// - reads or full buffers force write drain
// - 128-bit write two beats, smaller one
// - narrow writes aligned with lane selects
// - select clear: nocache bit; set: writethru
// - cache-allow sampled on every completing read cycle
// - dirty block flush writes block back
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH
`define BCC_CTRL_OFS 12'h000
`define BCC_STAT_OFS 12'h004
`define BCC_CTRL_PAGING 0
`define BCC_CTRL_ATTR 1
`define BCC_CTRL_INVAL 2
`define BCC_CTRL_BOOT 3
`define BCC_CTRL_ROW_LO 4
`define BCC_CTRL_ROW_HI 6
`define BCC_STAT_CNT_LO 0
`define BCC_STAT_CNT_HI 1
`define BCC_STAT_WB0 2
`define BCC_STAT_WB1 3
`define BCC_STAT_BOOT 4
`define BCC_MAX_OUT 2'h3
`define BCC_SZ_64 3'h3
`define BCC_SZ_128 3'h4
`define BCC_ROW_SHIFT 5'h06
`define BCC_BLK_HALF 32'h0000_0010
`define BCC_LANES_HI 5'h1f
`define BCC_HINT_IDLE 1'b1
`endif

// *** design/bcc_pkg.sv ***
// types and helper functions of the bus and cache control block
`include "bcc_regs.svh"
package bcc_pkg;
  typedef enum logic [1:0] {
    BCC_IFETCH = 2'b00,
    BCC_DREAD = 2'b01,
    BCC_DWRITE = 2'b10,
    BCC_FLUSH = 2'b11
  } bcc_kind_e;
  typedef struct packed {
    logic rd;
    logic ifetch;
    logic nc;
    logic wthru;
  } bcc_tag_s;
  typedef struct packed {
    logic valid;
    logic second;
    logic [31:0] addr;
    logic [2:0] size;
    logic [127:0] data;
  } bcc_wb_s;
  // active-low lane selects for a size code (log2 bytes) at a byte offset
  function automatic logic [7:0] bcc_lanes_n(input logic [2:0] sz, input logic [2:0] off);
    logic [7:0] m;
    m = 8'hff;
    if (sz == 3'h0) m = 8'h01;
    if (sz == 3'h1) m = 8'h03;
    if (sz == 3'h2) m = 8'h0f;
    if (sz < `BCC_SZ_64) m = m << off;
    return ~m;
  endfunction : bcc_lanes_n
  // row number of a word address for a row size code
  function automatic logic [28:0] bcc_row(input logic [28:0] a, input logic [2:0] sz);
    return a >> (`BCC_ROW_SHIFT + {2'h0, sz});
  endfunction : bcc_row
endpackage : bcc_pkg

// *** design/bcc_wbuf.sv ***
// one 128-bit write buffer, emptied as one or two 64-bit beats
`timescale 1ns/1ps
`include "bcc_regs.svh"
module bcc_wbuf
  import bcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [31:0] ld_addr,
  input wire logic [2:0] ld_size,
  input wire logic [127:0] ld_data,
  input wire logic take,
  output logic busy,
  output logic [28:0] beat_addr,
  output logic [7:0] beat_lanes_n,
  output logic [63:0] beat_data
);
  bcc_wb_s q, d;
  logic [63:0] half;
  always_comb
  begin
    d = q;
    if (take && q.valid)
    begin
      if (q.size == `BCC_SZ_128 && !q.second)
        d.second = 1'b1;
      else
        d = '0;
    end
    if (load && !q.valid)
    begin
      d.valid = 1'b1;
      d.second = 1'b0;
      d.addr = ld_addr;
      d.size = ld_size;
      d.data = ld_data;
    end
    half = q.second ? q.data[127:64] : q.data[63:0];
    beat_addr = q.addr[31:3] + {28'h0, q.second};
    beat_lanes_n = bcc_lanes_n(q.size, q.addr[2:0]);
    beat_data = (q.size >= `BCC_SZ_64) ? half : half << {q.addr[2:0], 3'h0};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end
  assign busy = q.valid;
endmodule : bcc_wbuf

// *** design/bcc_top.sv ***
// bus and cache control: cacheability, bus cycle issue, write buffers, apb registers
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "bcc_regs.svh"
module bcc_top
  import bcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [31:0] req_addr,
  input wire logic [2:0] req_size,
  input wire logic [255:0] req_wdata,
  input wire logic req_nocache,
  input wire logic req_writethru,
  input wire logic req_dirty,
  output logic req_ack,
  output logic rsp_valid,
  output logic [63:0] rsp_rdata,
  output logic rsp_fill,
  output logic flush_done,
  output logic icache_tlb_inval,
  input wire logic ic_hit,
  input wire logic [63:0] ic_rdata,
  input wire logic dc_hit,
  input wire logic [127:0] dc_rdata,
  output logic fetch_valid,
  output logic [63:0] fetch_data,
  output logic load_valid,
  output logic [127:0] load_data,
  input wire logic boot_irq_in,
  output logic bus_start,
  output logic [28:0] bus_addr,
  output logic bus_write,
  output logic [7:0] byte_lane_sel_n,
  output logic [63:0] bus_wdata,
  input wire logic [63:0] bus_rdata,
  input wire logic bus_ready_n,
  input wire logic cache_allow_n,
  output logic page_attr_out,
  output logic same_row_hint_n
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic paging;
    logic attr_sel;
    logic boot;
    logic boot_seen;
    logic [2:0] row_sz;
    logic inval;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ack;
    logic start;
    logic [28:0] baddr;
    logic bwr;
    logic [7:0] lanes_n;
    logic [63:0] bwdata;
    logic pattr;
    logic same_n;
    logic prev_v;
    logic [28:0] prev_addr;
    logic [1:0] cnt;
    bcc_tag_s [2:0] tag;
    logic rsp_v;
    logic rsp_fill;
    logic [63:0] rsp_data;
    logic flush_done;
    logic ifv;
    logic [63:0] ifd;
    logic dcv;
    logic [127:0] dcd;
    logic wold;
  } bcc_st_s;
  bcc_st_s q, d;
  logic [1:0] wb_busy;
  logic [1:0] wb_load;
  logic [1:0] wb_take;
  logic [1:0][31:0] ld_addr;
  logic [1:0][2:0] ld_size;
  logic [1:0][127:0] ld_data;
  logic [1:0][28:0] wb_addr;
  logic [1:0][7:0] wb_lanes_n;
  logic [1:0][63:0] wb_data;
  ////////////////////////////////////////////////////////////////////////////////
  bcc_wbuf u_wb0 (
    .pclk(pclk),
    .presetn(presetn),
    .load(wb_load[0]),
    .ld_addr(ld_addr[0]),
    .ld_size(ld_size[0]),
    .ld_data(ld_data[0]),
    .take(wb_take[0]),
    .busy(wb_busy[0]),
    .beat_addr(wb_addr[0]),
    .beat_lanes_n(wb_lanes_n[0]),
    .beat_data(wb_data[0])
  );
  bcc_wbuf u_wb1 (
    .pclk(pclk),
    .presetn(presetn),
    .load(wb_load[1]),
    .ld_addr(ld_addr[1]),
    .ld_size(ld_size[1]),
    .ld_data(ld_data[1]),
    .take(wb_take[1]),
    .busy(wb_busy[1]),
    .beat_addr(wb_addr[1]),
    .beat_lanes_n(wb_lanes_n[1]),
    .beat_data(wb_data[1])
  );
  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic is_rd;
    logic pop;
    logic room;
    logic need;
    logic dr;
    logic fb;
    logic issue;
    logic [1:0] ncnt;
    logic [28:0] row;
    bcc_tag_s t;
    is_rd = 1'b0;
    pop = 1'b0;
    room = 1'b0;
    need = 1'b0;
    dr = 1'b0;
    fb = 1'b0;
    issue = 1'b0;
    ncnt = 2'h0;
    row = '0;
    t = '0;
    d = q;
    wb_load = 2'b00;
    wb_take = 2'b00;
    ld_addr = {req_addr + `BCC_BLK_HALF, req_addr};
    ld_size = {2{req_size}};
    ld_data = {2{req_wdata[127:0]}};
    d.inval = 1'b0;
    d.ack = 1'b0;
    d.start = 1'b0;
    d.rsp_v = 1'b0;
    d.flush_done = 1'b0;
    // strap is caught on the first edge after release, never under reset
    d.boot_seen = 1'b1;
    if (!q.boot_seen)
      d.boot = boot_irq_in;
    // apb: zero-wait, data and error prepared in the setup cycle
    d.pready = psel & ~penable & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (psel && !penable)
    begin
      if (paddr == `BCC_CTRL_OFS)
      begin
        d.prdata[`BCC_CTRL_PAGING] = q.paging;
        d.prdata[`BCC_CTRL_ATTR] = q.attr_sel;
        d.prdata[`BCC_CTRL_BOOT] = q.boot;
        d.prdata[`BCC_CTRL_ROW_HI:`BCC_CTRL_ROW_LO] = q.row_sz;
      end
      else if (paddr == `BCC_STAT_OFS)
      begin
        d.prdata[`BCC_STAT_CNT_HI:`BCC_STAT_CNT_LO] = q.cnt;
        d.prdata[`BCC_STAT_WB0] = wb_busy[0];
        d.prdata[`BCC_STAT_WB1] = wb_busy[1];
        d.prdata[`BCC_STAT_BOOT] = q.boot;
      end
      else
        d.pslverr = 1'b1;
    end
    if (psel && penable && q.pready && pwrite && paddr == `BCC_CTRL_OFS)
    begin
      d.paging = pwdata[`BCC_CTRL_PAGING];
      d.attr_sel = pwdata[`BCC_CTRL_ATTR];
      d.inval = pwdata[`BCC_CTRL_INVAL];
      d.row_sz = pwdata[`BCC_CTRL_ROW_HI:`BCC_CTRL_ROW_LO];
      // only a clear gets through; a written one is ignored
      d.boot = d.boot & pwdata[`BCC_CTRL_BOOT];
    end
    // cache hit paths, one word of each per cycle
    d.ifv = ic_hit;
    d.ifd = ic_rdata;
    d.dcv = dc_hit;
    d.dcd = dc_rdata;
    // completion of the oldest outstanding cycle
    pop = ~bus_ready_n & (q.cnt != 2'h0);
    if (pop)
    begin
      t = q.tag[0];
      d.tag[0] = q.tag[1];
      d.tag[1] = q.tag[2];
      d.tag[2] = '0;
      if (t.rd)
      begin
        d.rsp_v = 1'b1;
        d.rsp_data = (q.boot && t.ifetch) ? {56'h0, bus_rdata[7:0]} : bus_rdata;
        // allow input taken on every completing read cycle
        d.rsp_fill = ~cache_allow_n & ~(t.nc | t.wthru);
      end
    end
    ncnt = q.cnt - {1'b0, pop};
    room = (q.cnt != `BCC_MAX_OUT) | pop;
    is_rd = (req_kind == BCC_IFETCH) | (req_kind == BCC_DREAD);
    // a held write would otherwise wait forever behind full buffers
    need = is_rd | q.ack;
    need = need | ((req_kind == BCC_DWRITE) & (&wb_busy));
    need = need | ((req_kind == BCC_FLUSH) & req_dirty & (|wb_busy));
    dr = wb_busy[q.wold] ? q.wold : ~q.wold;
    fb = wb_busy[0];
    // writes wait while a store into a free buffer or a clean flush is pending
    if ((|wb_busy) && room && (!req_valid || need))
    begin
      wb_take[dr] = 1'b1;
      d.start = 1'b1;
      d.bwr = 1'b1;
      d.baddr = wb_addr[dr];
      d.lanes_n = wb_lanes_n[dr];
      d.bwdata = wb_data[dr];
      d.pattr = 1'b0;
      d.tag[ncnt] = '0;
      issue = 1'b1;
      if (!wb_busy[~dr])
        d.wold = ~dr;
    end
    else if (req_valid && !q.ack && is_rd && wb_busy == 2'b00 && room)
    begin
      d.ack = 1'b1;
      d.start = 1'b1;
      d.bwr = 1'b0;
      d.baddr = req_addr[31:3];
      d.bwdata = '0;
      t.rd = 1'b1;
      t.ifetch = (req_kind == BCC_IFETCH);
      t.nc = q.paging & req_nocache;
      t.wthru = q.paging & req_writethru & ~t.ifetch;
      d.tag[ncnt] = t;
      d.lanes_n = '0;
      if (q.boot && t.ifetch)
        d.lanes_n = {`BCC_LANES_HI, req_addr[2:0]};
      // not asserted at all while paging is off
      d.pattr = q.paging & (q.attr_sel ? req_writethru : req_nocache);
      issue = 1'b1;
    end
    if (issue)
    begin
      // both rows at today's size, so a size change never compares stale rows
      row = bcc_row(d.baddr, q.row_sz);
      d.same_n = ~(q.prev_v & (row == bcc_row(q.prev_addr, q.row_sz)));
      d.prev_v = 1'b1;
      d.prev_addr = d.baddr;
    end
    d.cnt = ncnt + {1'b0, issue};
    // stores and flushes go into free buffers only
    if (req_valid && !q.ack && req_kind == BCC_DWRITE && !(&wb_busy))
    begin
      wb_load[fb] = 1'b1;
      ld_addr[fb] = req_addr;
      ld_size[fb] = req_size;
      d.ack = 1'b1;
      d.wold = wb_busy[~fb] ? ~fb : fb;
    end
    if (req_valid && !q.ack && req_kind == BCC_FLUSH)
    begin
      if (!req_dirty)
      begin
        d.ack = 1'b1;
        d.flush_done = 1'b1;
      end
      else if (wb_busy == 2'b00)
      begin
        wb_load = 2'b11;
        ld_size = {2{`BCC_SZ_128}};
        ld_data = {req_wdata[255:128], req_wdata[127:0]};
        d.wold = 1'b0;
        d.ack = 1'b1;
        d.flush_done = 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.same_n <= `BCC_HINT_IDLE;
    end
    else
      q <= d;
  end
  ////////////////////////////////////////////////////////////////////////////////
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign req_ack = q.ack;
  assign rsp_valid = q.rsp_v;
  assign rsp_rdata = q.rsp_data;
  assign rsp_fill = q.rsp_fill;
  assign flush_done = q.flush_done;
  assign icache_tlb_inval = q.inval;
  assign fetch_valid = q.ifv;
  assign fetch_data = q.ifd;
  assign load_valid = q.dcv;
  assign load_data = q.dcd;
  assign bus_start = q.start;
  assign bus_addr = q.baddr;
  assign bus_write = q.bwr;
  assign byte_lane_sel_n = q.lanes_n;
  assign bus_wdata = q.bwdata;
  assign page_attr_out = q.pattr;
  assign same_row_hint_n = q.same_n;
endmodule : bcc_top

// *** testbench/bcc_props.sv ***
// concurrent checks on the ports of the bus and cache control block
`timescale 1ns/1ps
module bcc_props
  import bcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_dirty,
  input wire logic req_ack,
  input wire logic rsp_valid,
  input wire logic flush_done,
  input wire logic icache_tlb_inval,
  input wire logic ic_hit,
  input wire logic [63:0] ic_rdata,
  input wire logic dc_hit,
  input wire logic [127:0] dc_rdata,
  input wire logic fetch_valid,
  input wire logic [63:0] fetch_data,
  input wire logic load_valid,
  input wire logic [127:0] load_data,
  input wire logic bus_start,
  input wire logic bus_ready_n,
  input wire logic same_row_hint_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] cnt_q;
  logic seen_q;
  // outstanding cycles: a start counts up, a ready with one open counts down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 3'h0;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 3'(bus_start) - 3'(!bus_ready_n && cnt_q != 3'h0);
      seen_q <= seen_q | bus_start;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  a_apb_ready: assert property (s_setup |=> pready) else $error("pready late");
  a_apb_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_apb_unmapped: assert property (s_setup ##0 (paddr != 12'h000 && paddr != 12'h004)
    |=> pslverr) else $error("no slave error");
  a_inval_pulse: assert property (s_ctrl_wr ##0 pwdata[2] |-> ##[1:2] icache_tlb_inval)
    else $error("no invalidate");
  a_fetch_pipe: assert property (ic_hit |=> fetch_valid && fetch_data == $past(ic_rdata))
    else $error("fetch lost");
  a_load_pipe: assert property (dc_hit |=> load_valid && load_data == $past(dc_rdata))
    else $error("load lost");
  a_max_three: assert property (bus_start |-> cnt_q < 3'h3)
    else $error("fourth cycle");
  a_rsp_cause: assert property (rsp_valid |-> !$past(bus_ready_n)) else $error("rsp no ready");
  a_read_issue: assert property (req_ack && !req_kind[1] |-> bus_start)
    else $error("read not issued");
  a_first_hint: assert property (bus_start && !seen_q |-> same_row_hint_n)
    else $error("hint on first");
  a_flush_clean: assert property (
    req_valid && req_kind == 2'b11 && !req_dirty && !req_ack
    |-> ##[1:2] flush_done) else $error("flush not done");
endmodule : bcc_props
bind bcc_top bcc_props u_bcc_props (.*);

// *** testbench/bcc_mem_model.sv ***
// behavioural memory and i/o side answering bus cycles in order
`timescale 1ns/1ps
module bcc_mem_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_start,
  input wire logic [28:0] bus_addr,
  input wire logic slow,
  output logic [63:0] bus_rdata,
  output logic bus_ready_n
);
  logic [28:0] q[$];
  int w;
  function automatic logic [63:0] pat(input logic [28:0] a);
    return {3'h5, ~a, 3'h2, a};
  endfunction : pat
  // ready never before the second edge after a start; data inverted once released
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q.delete();
      w <= 0;
      bus_ready_n <= 1'b1;
      bus_rdata <= 64'h0;
    end
    else
    begin
      if (bus_start)
        q.push_back(bus_addr);
      if (!bus_ready_n)
      begin
        bus_ready_n <= 1'b1;
        bus_rdata <= ~bus_rdata;
      end
      else if (q.size() > 0 && w >= (slow ? 12 : 1))
      begin
        bus_ready_n <= 1'b0;
        bus_rdata <= pat(q.pop_front());
        w <= 0;
      end
      else if (q.size() > 0)
        w <= w + 1;
    end
  end
endmodule : bcc_mem_model

// *** testbench/tb.sv ***
// self-checking bench of the bus and cache control block
`timescale 1ns/1ps
module tb
  import bcc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, req_addr = '0, a;
  logic req_valid = 0, req_nocache = 0, req_writethru = 0, req_dirty = 0, req_ack;
  logic [1:0] req_kind = '0;
  logic [2:0] req_size = '0;
  logic [255:0] req_wdata = '0, dat;
  logic rsp_valid, rsp_fill, flush_done, icache_tlb_inval, fetch_valid, load_valid;
  logic [63:0] rsp_rdata, fetch_data, ic_rdata = '0, bus_wdata, bus_rdata;
  logic ic_hit = 0, dc_hit = 0, boot_irq_in = 0, bus_start, bus_write, bus_ready_n;
  logic [127:0] dc_rdata = '0, load_data;
  logic [28:0] bus_addr, prev;
  logic [7:0] byte_lane_sel_n;
  logic cache_allow_n = 0, page_attr_out, same_row_hint_n, slow = 0, first = 1, al = 0;
  logic [6:0] ctl = '0;
  logic [32:0] aq[$];
  logic [64:0] rq[$];
  logic [102:0] bq[$];
  int fails = 0, comparisons = 0, i;
  integer seed = 32'h034b;
  bcc_top u_bcc_top (.*);
  bcc_mem_model u_bcc_mem_model (.*);
  initial forever #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task end_of_test;
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task hang;
    fails++;
    end_of_test;
  endtask : hang
  task cmp(input logic [127:0] e, input logic [127:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp
  function automatic logic [63:0] pat(input logic [28:0] x);
    return {3'h5, ~x, 3'h2, x};
  endfunction : pat
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    aq.push_back(e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang;
    {psel, penable} <= 2'b00;
  endtask : apb
  task setc(input logic [6:0] v);
    ctl = {v[6:4], ctl[3] & v[3], 1'b0, v[1:0]};
    apb(1, 12'h000, {25'h0, v}, 33'h0);
  endtask : setc
  task req(input logic [1:0] k, input logic [31:0] ad, input logic [2:0] s,
    input logic [255:0] d, input logic nc, input logic wth, input logic dt);
    int n;
    @(posedge pclk);
    {req_valid, req_kind, req_addr, req_size} <= {1'b1, k, ad, s};
    {req_wdata, req_nocache, req_writethru, req_dirty} <= {d, nc, wth, dt};
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (req_ack !== 1'b1 && n < 200);
    if (n >= 200) hang;
    req_valid <= 0;
  endtask : req
  task rd(input logic [1:0] k, input logic [31:0] ad, input logic nc, input logic wth);
    logic [63:0] p;
    logic bt;
    p = pat(ad[31:3]);
    bt = ctl[3] && k == 2'b00;
    bq.push_back({1'b0, ad[31:3], bt ? {5'h1f, ad[2:0]} : 8'h00,
      ctl[0] && (ctl[1] ? wth : nc), 64'h0});
    rq.push_back({!al && !(ctl[0] && (nc || (wth && k == 2'b01))), bt ? {56'h0, p[7:0]} : p});
    req(k, ad, 3'h3, '0, nc, wth, 0);
  endtask : rd
  task wr(input logic [31:0] ad, input logic [2:0] s, input logic fl);
    logic [2:0] o;
    o = ad[2:0];
    for (int j = 0; j < (fl ? 4 : s == 3'h4 ? 2 : 1); j++)
      bq.push_back({1'b1, ad[31:3] + 29'(j), s > 2 ? 8'h00 : ~(((8'h1 << (1 << s)) - 8'h1) << o),
        1'b0, s > 2 || fl ? dat[64 * j +: 64] : dat[63:0] << (8 * o)});
    req(fl ? 2'b11 : 2'b10, ad, s, dat, 0, 0, fl);
  endtask : wr
  task idle;
    int n;
    n = 0;
    while ((rq.size() > 0 || bq.size() > 0) && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) hang;
  endtask : idle
  task rst(input logic b);
    @(posedge pclk);
    presetn <= 0;
    boot_irq_in <= b;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    boot_irq_in <= 0;
    ctl = {3'h0, b, 3'h0};
  endtask : rst
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    ic_hit <= 1'($random(seed));
    dc_hit <= 1'($random(seed));
    ic_rdata <= {2{$random(seed)}};
    dc_rdata <= {4{$random(seed)}};
  end
  always @(posedge pclk)
  begin
    if (!presetn)
      first = 1;
    else
    begin
      if (pready === 1'b1)
        cmp(aq.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
      if (rsp_valid === 1'b1)
        cmp(rq.pop_front(), {rsp_fill, rsp_rdata});
      if (bus_start === 1'b1)
      begin
        cmp(bq.pop_front(), {bus_write, bus_addr, byte_lane_sel_n, page_attr_out,
          bus_write ? bus_wdata : 64'h0});
        cmp(first || (bus_addr >> (6 + ctl[6:4])) != (prev >> (6 + ctl[6:4])),
          same_row_hint_n);
        prev = bus_addr;
        first = 0;
      end
    end
  end
  initial
  begin
    rst(1);
    apb(0, 12'h004, 0, 33'h10);
    apb(0, 12'h000, 0, 33'h8);
    rd(2'b00, 32'h1235, 0, 0);
    idle;
    setc(7'h00);
    setc(7'h08);
    apb(0, 12'h000, 0, 33'h0);
    rd(2'b00, 32'h1238, 0, 0);
    idle;
    rst(0);
    apb(1, 12'h008, 32'hff, 33'h1_0000_0000);
    apb(0, 12'h00c, 0, 33'h1_0000_0000);
    for (i = 0; i < 24; i++)
    begin
      idle;
      setc({3'($random(seed)), 2'b01, 2'($random(seed))});
      al = 1'($random(seed));
      cache_allow_n <= al;
      a = 32'h4000 + (32'($random(seed)) & 32'h3f8);
      rd(2'($random(seed) & 1), a, 1'($random(seed)), 1'($random(seed)));
    end
    idle;
    al = 0;
    cache_allow_n <= 0;
    slow <= 1;
    for (i = 0; i < 4; i++)
      rd(2'b01, 32'h8000 + 32'(i * 8), 0, 0);
    idle;
    slow <= 0;
    dat = {8{$random(seed)}};
    for (i = 0; i < 5; i++)
      wr(32'h9000 + 32'(i * 32) + (i < 3 ? 32'($random(seed)) & 7 & ~((1 << i) - 1) : 0),
        3'(i), 0);
    wr(32'ha000, 3'h4, 0);
    rd(2'b01, 32'ha010, 0, 0);
    wr(32'hb000, 3'h3, 1);
    req(2'b11, 32'hb020, 3'h3, '0, 0, 0, 0);
    idle;
    end_of_test;
  end
endmodule : tb
